// ### crbp_pkg.sv
// shared constants and types for the control register bus port
package crbp_pkg;
  localparam int unsigned CRBP_ADDR_W      = 10;
  localparam int unsigned CRBP_DATA_W      = 32;
  localparam int unsigned CRBP_HALF_W      = 5;
  localparam int unsigned CRBP_TIMEOUT_CYC = 64;
  localparam int unsigned CRBP_DROP_DLY    = 2;
  localparam int unsigned CRBP_CNT_W       = 7;
  localparam logic [CRBP_DATA_W-1:0] CRBP_WDATA_RST = 32'h0000_0000;
  localparam logic [CRBP_ADDR_W-1:0] CRBP_ADDR_RST  = 10'h000;
  localparam logic [CRBP_DATA_W-1:0] CRBP_RDATA_RST = 32'h0000_0000;
  localparam logic [CRBP_DATA_W-1:0] CRBP_REG_RST   = 32'h0000_0000;
  localparam logic [CRBP_CNT_W-1:0]  CRBP_CNT_RST   = 7'h00;
  localparam logic                   CRBP_MODE_LATCHED = 1'b0;
  localparam logic                   CRBP_MODE_ONE     = 1'b1;
  localparam logic                   CRBP_ACK_LATCHED  = 1'b1;

  typedef enum logic [0:0] {
    CRBP_MODE0,
    CRBP_MODE1
  } crbp_mode_t;

  // turn the instruction's swapped field into the plain register number
  function automatic logic [CRBP_ADDR_W-1:0] crbp_unswap(
    input logic [CRBP_ADDR_W-1:0] field
  );
    crbp_unswap = {field[CRBP_HALF_W-1:0], field[CRBP_ADDR_W-1:CRBP_HALF_W]};
  endfunction : crbp_unswap
endpackage : crbp_pkg

// ### crbp_if.sv
// interface joining the processor port to the peripheral chain
`timescale 1ns/1ns
`default_nettype none
interface crbp_if;
  import crbp_pkg::*;
  logic                   ctrl_reg_read_req;
  logic                   ctrl_reg_write_req;
  logic [CRBP_ADDR_W-1:0] ctrl_reg_addr;
  logic [CRBP_DATA_W-1:0] ctrl_reg_wdata_out;
  logic                   ctrl_reg_ack_in;
  logic [CRBP_DATA_W-1:0] ctrl_reg_rdata_in;

  modport proc (
    output ctrl_reg_read_req,
    output ctrl_reg_write_req,
    output ctrl_reg_addr,
    output ctrl_reg_wdata_out,
    input  ctrl_reg_ack_in,
    input  ctrl_reg_rdata_in
  );

  modport periph (
    input  ctrl_reg_read_req,
    input  ctrl_reg_write_req,
    input  ctrl_reg_addr,
    input  ctrl_reg_wdata_out,
    output ctrl_reg_ack_in,
    output ctrl_reg_rdata_in
  );
endinterface : crbp_if
`default_nettype wire

// ### crbp_proc.sv
// processor end of the control register bus
`timescale 1ns/1ns
`default_nettype none
// How it works
// - ten bit address, two data buses, strobes
// - peripherals chain read data onward
// - acknowledge latched along chain or ORed
// - each access lasts at least three cycles
// - no acknowledge in 64 cycles: silent abandon
// - mode zero: ack held until request drops
// - mode one: ack drops after one cycle
// - handshake mode fixed when built
// - address driven one cycle before request
// - request drops two cycles after ack
// - only ack or timeout ends a request
// - requests inactive during reset
// - peripheral drives data only when read-selected
// - new address after ack low one cycle
// - bus carries plain register number
// - write data on writes, zeros on reads
// - write bus zero during reset
// - ack only when owned, valid, ready
// - read data captured when ack seen
// - unimplemented bits pass chain read data through
// - registered ack with bypass multiplexer
// - never read and write together
module crbp_proc
  import crbp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = CRBP_TIMEOUT_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  crbp_if.proc                        bus,
  input  wire logic                   cmd_valid,
  input  wire logic                   cmd_write,
  input  wire logic [CRBP_ADDR_W-1:0] cmd_field,
  input  wire logic [CRBP_DATA_W-1:0] cmd_wdata,
  output logic                        cmd_ready,
  output logic                        done,
  output logic                        done_timeout,
  output logic [CRBP_DATA_W-1:0]      rdata
);

  typedef enum logic [2:0] {
    CRBP_IDLE,
    CRBP_SETUP,
    CRBP_REQ,
    CRBP_HOLD,
    CRBP_GAP
  } crbp_state_t;

  // whole port state, registered as one word
  typedef struct packed {
    crbp_state_t            state;
    logic                   rd;
    logic                   wr;
    logic                   is_write;
    logic [CRBP_ADDR_W-1:0] addr;
    logic [CRBP_DATA_W-1:0] wdata;
    logic [CRBP_DATA_W-1:0] rdata;
    logic [CRBP_CNT_W-1:0]  cnt;
    logic                   ready;
    logic                   done;
    logic                   tmo;
  } crbp_proc_st_t;

  crbp_proc_st_t st_reg;
  crbp_proc_st_t st_next;
  logic          take_now;
  logic          tmo_now;
  logic          drop_now;

  ////////////////////////////////////////////////////////////////////////////
  // latch a new command: plain register number, zeros for reads
  function automatic crbp_proc_st_t take_cmd(
    input crbp_proc_st_t          cur,
    input logic                   is_wr,
    input logic [CRBP_ADDR_W-1:0] field,
    input logic [CRBP_DATA_W-1:0] wdata
  );
    crbp_proc_st_t nxt;
    nxt          = cur;
    nxt.state    = CRBP_SETUP;
    nxt.ready    = 1'b0;
    nxt.is_write = is_wr;
    nxt.addr     = crbp_unswap(field);
    nxt.wdata    = is_wr ? wdata : CRBP_WDATA_RST;
    return nxt;
  endfunction : take_cmd

  // end the access: both strobes low, write bus back to zero
  function automatic crbp_proc_st_t drop_req(
    input crbp_proc_st_t cur,
    input logic          timed_out
  );
    crbp_proc_st_t nxt;
    nxt       = cur;
    nxt.state = CRBP_GAP;
    nxt.rd    = 1'b0;
    nxt.wr    = 1'b0;
    nxt.wdata = CRBP_WDATA_RST;
    nxt.done  = 1'b1;
    nxt.tmo   = timed_out;
    return nxt;
  endfunction : drop_req

  // cycle counter that sticks at its top value instead of wrapping
  function automatic logic [CRBP_CNT_W-1:0] count_up(
    input logic [CRBP_CNT_W-1:0] cnt
  );
    logic [CRBP_CNT_W-1:0] top;
    top = '1;
    return (cnt == top) ? cnt : cnt + 7'h01;
  endfunction : count_up

  ////////////////////////////////////////////////////////////////////////////
  // command taken only once the previous ack has gone low
  assign take_now = cmd_valid && st_reg.ready && !bus.ctrl_reg_ack_in;
  assign tmo_now  = st_reg.cnt == CRBP_CNT_W'(TIMEOUT_CYC - 1);
  assign drop_now = st_reg.cnt == CRBP_CNT_W'(CRBP_DROP_DLY - 2);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    st_next.tmo  = 1'b0;
    case (st_reg.state)
      CRBP_IDLE: begin
        // ready rises on the first edge after reset
        st_next.ready = 1'b1;
        if (take_now) begin
          st_next = take_cmd(st_next, cmd_write, cmd_field, cmd_wdata);
        end
      end
      CRBP_SETUP: begin
        // address has stood one cycle; raise exactly one strobe
        st_next.state = CRBP_REQ;
        st_next.rd    = !st_reg.is_write;
        st_next.wr    = st_reg.is_write;
        st_next.cnt   = CRBP_CNT_RST;
      end
      CRBP_REQ: begin
        st_next.cnt = count_up(st_reg.cnt);
        if (bus.ctrl_reg_ack_in) begin
          if (!st_reg.is_write) begin
            st_next.rdata = bus.ctrl_reg_rdata_in;
          end
          st_next.state = CRBP_HOLD;
          st_next.cnt   = CRBP_CNT_RST;
        end else if (tmo_now) begin
          st_next = drop_req(st_next, 1'b1);
        end
      end
      CRBP_HOLD: begin
        // request stays up until the second edge after the ack
        st_next.cnt = count_up(st_reg.cnt);
        if (drop_now) begin
          st_next = drop_req(st_next, 1'b0);
        end
      end
      CRBP_GAP: begin
        // hold address until ack has been low a full cycle
        if (!bus.ctrl_reg_ack_in) begin
          st_next.state = CRBP_IDLE;
          st_next.ready = 1'b1;
        end
      end
      default: begin
        // unknown state: back to idle, strobes keep their value
        st_next.state = CRBP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // idle port: strobes low, write bus zero
      st_reg.state    <= CRBP_IDLE;
      st_reg.rd       <= 1'b0;
      st_reg.wr       <= 1'b0;
      st_reg.is_write <= 1'b0;
      st_reg.addr     <= CRBP_ADDR_RST;
      st_reg.wdata    <= CRBP_WDATA_RST;
      st_reg.rdata    <= CRBP_RDATA_RST;
      st_reg.cnt      <= CRBP_CNT_RST;
      st_reg.ready    <= 1'b0;
      st_reg.done     <= 1'b0;
      st_reg.tmo      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // every output straight from the state register
  assign bus.ctrl_reg_read_req  = st_reg.rd;
  assign bus.ctrl_reg_write_req = st_reg.wr;
  assign bus.ctrl_reg_addr      = st_reg.addr;
  assign bus.ctrl_reg_wdata_out = st_reg.wdata;
  assign cmd_ready              = st_reg.ready;
  assign done                   = st_reg.done;
  assign done_timeout           = st_reg.tmo;
  assign rdata                  = st_reg.rdata;

endmodule : crbp_proc
`default_nettype wire

// ### crbp_periph.sv
// one chained peripheral stage holding a block of registers
`timescale 1ns/1ns
`default_nettype none
module crbp_periph
  import crbp_pkg::*;
#(
  parameter logic [CRBP_ADDR_W-1:0] BASE_ADDR = 10'h000,
  parameter int unsigned            NUM_REGS  = 4,
  parameter logic [CRBP_DATA_W-1:0] IMPL_MASK = 32'hFFFF_FFFF,
  parameter logic                   MODE      = CRBP_MODE_LATCHED,
  parameter logic                   ACK_REGD  = CRBP_ACK_LATCHED
) (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  crbp_if.periph                      bus,
  input  wire logic [CRBP_DATA_W-1:0] chain_rdata_in,
  input  wire logic                   chain_ack_in,
  output logic [CRBP_DATA_W-1:0]      reg_value [NUM_REGS],
  output logic                        wr_strobe
);

  localparam int unsigned IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  typedef struct packed {
    logic                   ack;
    logic                   cack;
    logic                   done;
    logic                   wstb;
    logic [CRBP_DATA_W-1:0] rdata;
  } crbp_periph_st_t;

  crbp_periph_st_t        st_reg;
  crbp_periph_st_t        st_next;
  logic [CRBP_DATA_W-1:0] regs_reg [NUM_REGS];
  logic [CRBP_ADDR_W-1:0] offs;
  logic                   hit;
  logic                   req;
  logic [IDX_W-1:0]       idx;
  logic [CRBP_DATA_W-1:0] mine;

  ////////////////////////////////////////////////////////////////////////////
  assign offs = bus.ctrl_reg_addr - BASE_ADDR;
  assign hit  = (bus.ctrl_reg_addr >= BASE_ADDR) && (offs < CRBP_ADDR_W'(NUM_REGS));
  assign req  = bus.ctrl_reg_read_req || bus.ctrl_reg_write_req;
  assign idx  = offs[IDX_W-1:0];
  // only implemented bits replace the chain value
  assign mine = (regs_reg[idx] & IMPL_MASK) | (chain_rdata_in & ~IMPL_MASK);

  always_comb begin
    st_next      = st_reg;
    st_next.wstb = 1'b0;
    st_next.cack = chain_ack_in;
    st_next.rdata = (bus.ctrl_reg_read_req && hit) ? mine : chain_rdata_in;
    if (!req) begin
      st_next.ack  = 1'b0;
      st_next.done = 1'b0;
    end else if (hit && !st_reg.done) begin
      st_next.ack  = 1'b1;
      st_next.done = 1'b1;
      st_next.wstb = bus.ctrl_reg_write_req;
    end else if (MODE == CRBP_MODE_ONE) begin
      st_next.ack = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.ack   <= 1'b0;
      st_reg.cack  <= 1'b0;
      st_reg.done  <= 1'b0;
      st_reg.wstb  <= 1'b0;
      st_reg.rdata <= CRBP_RDATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // write capture; reset loads CRBP_REG_RST, not the bus
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= CRBP_REG_RST;
      end
    end else if (bus.ctrl_reg_write_req && hit && !st_reg.done) begin
      regs_reg[idx] <= bus.ctrl_reg_wdata_out & IMPL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus.ctrl_reg_rdata_in = st_reg.rdata;
  // registered ack forwarded, or ORed straight through
  assign bus.ctrl_reg_ack_in   = ACK_REGD ? (st_reg.ack | st_reg.cack) : (st_reg.ack | chain_ack_in);
  assign wr_strobe             = st_reg.wstb;
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_value[i] = regs_reg[i];
    end
  end

endmodule : crbp_periph
`default_nettype wire

// ### crbp_chk.sv
// assertions on the control register bus between the two ends
`timescale 1ns/1ns
`default_nettype none
module crbp_chk
  import crbp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = CRBP_TIMEOUT_CYC
) (
  input wire logic                   core_clk,
  input wire logic                   resetn,
  input wire logic                   ctrl_reg_read_req,
  input wire logic                   ctrl_reg_write_req,
  input wire logic [CRBP_ADDR_W-1:0] ctrl_reg_addr,
  input wire logic [CRBP_DATA_W-1:0] ctrl_reg_wdata_out,
  input wire logic                   ctrl_reg_ack_in,
  input wire logic [CRBP_DATA_W-1:0] ctrl_reg_rdata_in
);
  logic                  rq;
  logic [CRBP_CNT_W-1:0] wait_reg;
  assign rq = ctrl_reg_read_req | ctrl_reg_write_req;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // cycles of request still waiting for acknowledge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) wait_reg <= CRBP_CNT_RST;
    else if (!rq || ctrl_reg_ack_in) wait_reg <= CRBP_CNT_RST;
    else wait_reg <= wait_reg + 7'h01;
  end
  ////////////////////////////////////////////////////////////////
  a_no_rd_wr: assert property (!(ctrl_reg_read_req && ctrl_reg_write_req))
    else $error("read and write requested together");
  a_addr_setup: assert property ($rose(rq) |-> $stable(ctrl_reg_addr))
    else $error("address not driven before request");
  a_addr_hold: assert property (rq && $past(rq) |-> $stable(ctrl_reg_addr))
    else $error("address moved during request");
  a_new_addr_gap: assert property ($rose(rq) |-> !$past(ctrl_reg_ack_in, 2))
    else $error("new access too soon after acknowledge");
  a_drop_two: assert property ($rose(ctrl_reg_ack_in) |=> rq ##1 !rq)
    else $error("request not dropped two cycles after acknowledge");
  a_no_cancel: assert property ($fell(rq) |->
    $past(ctrl_reg_ack_in, 2) || wait_reg >= TIMEOUT_CYC - 1)
    else $error("request dropped without acknowledge or timeout");
  a_timeout_bound: assert property (wait_reg <= TIMEOUT_CYC + 1)
    else $error("unacknowledged request not abandoned");
  a_rd_wdata_zero: assert property (ctrl_reg_read_req |-> ctrl_reg_wdata_out == '0)
    else $error("write data not zero during read");
  a_min_three: assert property ($rose(rq) |-> rq [*3])
    else $error("access shorter than three cycles");
  a_ack_valid: assert property ($rose(ctrl_reg_ack_in) |-> rq && $past(rq))
    else $error("acknowledge without request");
  a_ack_hold: assert property (ctrl_reg_ack_in && rq |=> ctrl_reg_ack_in)
    else $error("acknowledge dropped before request");
  a_rdata_idle: assert property (!$past(ctrl_reg_read_req) |-> ctrl_reg_rdata_in == '0)
    else $error("read data driven without read request");
  a_addr_quiet: assert property ($changed(ctrl_reg_addr) |->
    !ctrl_reg_ack_in && !$past(ctrl_reg_ack_in))
    else $error("address changed while acknowledge was recent");
  c_read: cover property ($rose(ctrl_reg_ack_in) && ctrl_reg_read_req);
  c_write: cover property ($rose(ctrl_reg_ack_in) && ctrl_reg_write_req);
  c_timeout: cover property ($fell(rq) && !$past(ctrl_reg_ack_in, 2));
endmodule : crbp_chk
`default_nettype wire

// ### tb_top.sv
// self-checking bench joining both ends of the control register bus
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import crbp_pkg::*;
  localparam int unsigned TO_CYC = 8;
  localparam logic [CRBP_DATA_W-1:0] MASK = 32'h00FF_FFFF;
  logic                   core_clk, resetn, cmd_valid, cmd_write;
  logic                   cmd_ready, done, done_timeout, wr_strobe, t;
  logic [CRBP_ADDR_W-1:0] cmd_field, a;
  logic [CRBP_DATA_W-1:0] cmd_wdata, rdata, q;
  logic [CRBP_DATA_W-1:0] regs [4];
  int                     bad_count = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  int                     wstb_seen = 0;
  crbp_if bus_if ();
  crbp_proc #(.TIMEOUT_CYC(TO_CYC)) crbp_proc_i (.core_clk(core_clk), .resetn(resetn),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_field(cmd_field),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
    .done_timeout(done_timeout), .rdata(rdata));
  crbp_periph #(.BASE_ADDR(10'h2A8), .NUM_REGS(4), .IMPL_MASK(MASK),
    .MODE(CRBP_MODE_LATCHED), .ACK_REGD(CRBP_ACK_LATCHED)) crbp_periph_i (
    .core_clk(core_clk), .resetn(resetn), .bus(bus_if), .chain_rdata_in(32'h0000_0000),
    .chain_ack_in(1'b0), .reg_value(regs), .wr_strobe(wr_strobe));
  crbp_chk #(.TIMEOUT_CYC(TO_CYC)) crbp_chk_i (.core_clk(core_clk), .resetn(resetn),
    .ctrl_reg_read_req(bus_if.ctrl_reg_read_req),
    .ctrl_reg_write_req(bus_if.ctrl_reg_write_req),
    .ctrl_reg_addr(bus_if.ctrl_reg_addr), .ctrl_reg_wdata_out(bus_if.ctrl_reg_wdata_out),
    .ctrl_reg_ack_in(bus_if.ctrl_reg_ack_in),
    .ctrl_reg_rdata_in(bus_if.ctrl_reg_rdata_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [CRBP_DATA_W-1:0] s, input logic [CRBP_DATA_W-1:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // one access; entered just after a rising edge
  task automatic acc(input logic w, input logic [CRBP_ADDR_W-1:0] f,
                     input logic [CRBP_DATA_W-1:0] d);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_field = f;
    cmd_wdata = d;
    while (!(cmd_ready === 1'b1 && bus_if.ctrl_reg_ack_in === 1'b0) && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 200) bad_count++;
    q = rdata;
    t = done_timeout;
  endtask : acc
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (wr_strobe === 1'b1) wstb_seen <= wstb_seen + 1;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_field = 10'h000;
    cmd_wdata = 32'h0000_0000;
    repeat (6) @(posedge core_clk);
    #1 chk(bus_if.ctrl_reg_read_req | bus_if.ctrl_reg_write_req, 32'h0);
    chk(bus_if.ctrl_reg_wdata_out, 32'h0000_0000);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = 10'h2A8 + i[9:0];
      acc(1'b1, {a[4:0], a[9:5]}, 32'hA5C3_0F00 + i);
      chk(t, 1'b0);
      chk(regs[i], (32'hA5C3_0F00 + i) & MASK);
    end
    chk(wstb_seen, 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      a = 10'h2A8 + i[9:0];
      acc(1'b0, {a[4:0], a[9:5]}, 32'hFFFF_FFFF);
      chk(q, (32'hA5C3_0F00 + i) & MASK);
    end
    $display("test 1 done");
    acc(1'b0, 10'h008, 32'h0000_0000);
    chk(t, 1'b1);
    acc(1'b0, 10'h155, 32'h0000_0000);
    chk(q, 32'h00C3_0F02);
    chk(t, 1'b0);
    $display("test 2 done");
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_wdata = 32'h1234_5678;
    repeat (4) @(posedge core_clk);
    #1 resetn = 1'b0;
    cmd_valid = 1'b0;
    #1 chk(bus_if.ctrl_reg_read_req | bus_if.ctrl_reg_write_req, 32'h0);
    chk(bus_if.ctrl_reg_wdata_out, 32'h0000_0000);
    @(posedge core_clk);
    #1 resetn = 1'b1;
    acc(1'b0, 10'h155, 32'h0000_0000);
    chk(q, CRBP_REG_RST);
    chk(wstb_seen, 32'h0000_0004);
    $display("test 3 done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
